// ---- hw/eeprom_host.sv ----
// Purpose: bus master that drives a two-wire serial EEPROM
// Assumes: single master on the bus; device filters its own inputs
// Notes: sda_i passes two flops; read data leaves through a 2-entry buffer
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_host_params.svh"

// What this block does
// - start is data falling while clock is high; a transaction begins there.
// - data changes only while clock is low; high-clock changes mean start or stop.
// - bytes are eight bits; the receiver pulls data low on the ninth clock.
// - after start send seven-bit device address plus read/write bit, type code on top.
// - byte write is device address, word address, one data byte, then stop.
// - more data bytes instead of stop give page write, up to sixteen bytes.
// - poll with start plus address-write; no acknowledge means still busy.
// - to end a read, withhold acknowledge after a byte, then stop.
// - random read is dummy write of word address, repeated start, then read.
// - acknowledge 0 after a read byte gets the next byte, wrapping to zero.
// - software reset is start, nine clocks with data released, another start.
module eeprom_host #(
   parameter logic [3:0] DEV_TYPE_CODE = 4'h0 // value arbitrary; set to the part's code
) (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire eeprom_host_pkg::op_t cmd_op_i,
   input wire logic [10:0] cmd_addr_i,
   input wire logic [4:0] cmd_len_i,
   input wire logic wdata_valid_i,
   output logic wdata_ready_o,
   input wire logic [7:0] wdata_i,
   output logic rdata_valid_o,
   input wire logic rdata_ready_i,
   output logic [7:0] rdata_o,
   output logic done_o,
   output logic err_o,
   output logic scl_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o
);

   eeprom_host_pkg::state_t state_reg;
   eeprom_host_pkg::stage_t stage_reg;
   eeprom_host_pkg::op_t op_reg;
   logic [`QTR_W-1:0] qcnt_reg;
   logic [1:0] phase_reg;
   logic [3:0] bit_reg;
   logic [7:0] sh_reg;
   logic [10:0] addr_reg;
   logic [4:0] left_reg;
   logic nack_reg;
   logic retry_reg;
   logic sda_s1_reg;
   logic sda_s2_reg;
   logic scl_next;
   logic oe_n_next;
   logic tick;
   logic slot_end;
   logic push;
   logic pop;
   logic [7:0] buf_mem [0:1];
   logic buf_wr_reg;
   logic buf_rd_reg;
   logic [1:0] buf_cnt_reg;

   function automatic logic [7:0] dev_byte(input logic [3:0] code, input logic [2:0] hi,
                                           input logic rw);
      dev_byte = {code, hi, rw};
   endfunction : dev_byte

   // ***************************************************************
   // input synchroniser and slot timing
   // ***************************************************************
   always_ff @(posedge ref_clk_i)
   begin
      sda_s1_reg <= sda_i;
      sda_s2_reg <= sda_s1_reg;
   end

   assign tick = (qcnt_reg == `QTR_W'(`QTR_CYC - 1));
   assign slot_end = tick && (phase_reg == 2'h3);

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i || state_reg == eeprom_host_pkg::ST_IDLE
          || state_reg == eeprom_host_pkg::ST_WAIT)
      begin
         qcnt_reg <= '0;
         phase_reg <= 2'h0;
      end
      else if (tick)
      begin
         qcnt_reg <= '0;
         phase_reg <= phase_reg + 2'h1;
      end
      else
         qcnt_reg <= qcnt_reg + `QTR_W'(1);
   end

   // ***************************************************************
   // sequencer
   // ***************************************************************
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         state_reg <= eeprom_host_pkg::ST_IDLE;
         stage_reg <= eeprom_host_pkg::SG_DEV_W;
         op_reg <= eeprom_host_pkg::OP_WRITE;
         bit_reg <= 4'h0;
         sh_reg <= 8'h00;
         addr_reg <= 11'h000;
         left_reg <= 5'h00;
         nack_reg <= 1'b0;
         retry_reg <= 1'b0;
         done_o <= 1'b0;
         err_o <= 1'b0;
      end
      else
      begin
         done_o <= 1'b0;
         if (tick && phase_reg == 2'h2)
         begin
            if (state_reg == eeprom_host_pkg::ST_TX && bit_reg == `ACK_SLOT)
               nack_reg <= sda_s2_reg;
            if (state_reg == eeprom_host_pkg::ST_RX && bit_reg != `ACK_SLOT)
               sh_reg <= {sh_reg[6:0], sda_s2_reg};
         end
         case (state_reg)
            eeprom_host_pkg::ST_IDLE:
               if (cmd_valid_i)
               begin
                  op_reg <= cmd_op_i;
                  addr_reg <= cmd_addr_i;
                  err_o <= 1'b0;
                  retry_reg <= 1'b0;
                  if (cmd_len_i == 5'h00)
                     left_reg <= 5'h01;
                  else if (cmd_op_i == eeprom_host_pkg::OP_WRITE && cmd_len_i > `PAGE_BYTES)
                     left_reg <= `PAGE_BYTES;
                  else
                     left_reg <= cmd_len_i;
                  if (cmd_op_i == eeprom_host_pkg::OP_CUR_READ)
                     stage_reg <= eeprom_host_pkg::SG_DEV_R;
                  else if (cmd_op_i == eeprom_host_pkg::OP_SRESET)
                     stage_reg <= eeprom_host_pkg::SG_SRST1;
                  else
                     stage_reg <= eeprom_host_pkg::SG_DEV_W;
                  state_reg <= eeprom_host_pkg::ST_START;
               end
            eeprom_host_pkg::ST_START:
               if (slot_end)
               begin
                  bit_reg <= 4'h0;
                  retry_reg <= 1'b0;
                  state_reg <= eeprom_host_pkg::ST_TX;
                  if (stage_reg == eeprom_host_pkg::SG_SRST1)
                     sh_reg <= `DUMMY_BYTE;
                  else if (stage_reg == eeprom_host_pkg::SG_SRST2)
                     state_reg <= eeprom_host_pkg::ST_STOP;
                  else if (stage_reg == eeprom_host_pkg::SG_DEV_R)
                     sh_reg <= dev_byte(DEV_TYPE_CODE, addr_reg[10:8], `CMD_READ);
                  else
                     sh_reg <= dev_byte(DEV_TYPE_CODE, addr_reg[10:8], `CMD_WRITE);
               end
            eeprom_host_pkg::ST_TX:
               if (slot_end && bit_reg != `ACK_SLOT)
               begin
                  bit_reg <= bit_reg + 4'h1;
                  sh_reg <= {sh_reg[6:0], 1'b1};
               end
               else if (slot_end)
               begin
                  bit_reg <= 4'h0;
                  state_reg <= eeprom_host_pkg::ST_STOP;
                  if (stage_reg == eeprom_host_pkg::SG_SRST1)
                  begin
                     stage_reg <= eeprom_host_pkg::SG_SRST2;
                     state_reg <= eeprom_host_pkg::ST_START;
                  end
                  else if (nack_reg && stage_reg == eeprom_host_pkg::SG_DEV_W
                           && op_reg == eeprom_host_pkg::OP_POLL)
                     retry_reg <= 1'b1;
                  else if (nack_reg)
                     err_o <= 1'b1;
                  else if (stage_reg == eeprom_host_pkg::SG_DEV_W
                           && op_reg != eeprom_host_pkg::OP_POLL)
                  begin
                     sh_reg <= addr_reg[7:0];
                     stage_reg <= eeprom_host_pkg::SG_WADDR;
                     state_reg <= eeprom_host_pkg::ST_TX;
                  end
                  else if (stage_reg == eeprom_host_pkg::SG_WADDR
                           && op_reg == eeprom_host_pkg::OP_READ)
                  begin
                     stage_reg <= eeprom_host_pkg::SG_DEV_R;
                     state_reg <= eeprom_host_pkg::ST_START;
                  end
                  else if (stage_reg == eeprom_host_pkg::SG_WADDR)
                  begin
                     stage_reg <= eeprom_host_pkg::SG_DATA;
                     state_reg <= eeprom_host_pkg::ST_WAIT;
                  end
                  else if (stage_reg == eeprom_host_pkg::SG_DATA)
                  begin
                     left_reg <= left_reg - 5'h01;
                     if (left_reg != 5'h01)
                        state_reg <= eeprom_host_pkg::ST_WAIT;
                  end
                  else if (stage_reg == eeprom_host_pkg::SG_DEV_R)
                  begin
                     stage_reg <= eeprom_host_pkg::SG_RDATA;
                     state_reg <= eeprom_host_pkg::ST_WAIT;
                  end
               end
            eeprom_host_pkg::ST_WAIT:
               if (stage_reg == eeprom_host_pkg::SG_DATA && wdata_valid_i)
               begin
                  sh_reg <= wdata_i;
                  bit_reg <= 4'h0;
                  state_reg <= eeprom_host_pkg::ST_TX;
               end
               else if (stage_reg == eeprom_host_pkg::SG_RDATA && buf_cnt_reg != `BUF_DEPTH)
               begin
                  bit_reg <= 4'h0;
                  state_reg <= eeprom_host_pkg::ST_RX;
               end
            eeprom_host_pkg::ST_RX:
               if (slot_end && bit_reg != `ACK_SLOT)
                  bit_reg <= bit_reg + 4'h1;
               else if (slot_end)
               begin
                  left_reg <= left_reg - 5'h01;
                  if (left_reg == 5'h01)
                     state_reg <= eeprom_host_pkg::ST_STOP;
                  else
                     state_reg <= eeprom_host_pkg::ST_WAIT;
               end
            eeprom_host_pkg::ST_STOP:
               if (slot_end && retry_reg)
                  state_reg <= eeprom_host_pkg::ST_START;
               else if (slot_end)
               begin
                  done_o <= 1'b1;
                  state_reg <= eeprom_host_pkg::ST_IDLE;
               end
            default:
               state_reg <= eeprom_host_pkg::ST_IDLE;
         endcase
      end
   end

   assign cmd_ready_o = (state_reg == eeprom_host_pkg::ST_IDLE);
   assign wdata_ready_o = (state_reg == eeprom_host_pkg::ST_WAIT)
                          && (stage_reg == eeprom_host_pkg::SG_DATA);

   // ***************************************************************
   // pin drive: clock low in quarters 0 and 3 of each start, data and acknowledge slot; stop slot low only in quarter 0
   // ***************************************************************
   always_comb
   begin
      scl_next = 1'b1;
      oe_n_next = 1'b1;
      case (state_reg)
         eeprom_host_pkg::ST_START:
         begin
            scl_next = (phase_reg == 2'h1) || (phase_reg == 2'h2);
            oe_n_next = !phase_reg[1];
         end
         eeprom_host_pkg::ST_STOP:
         begin
            scl_next = (phase_reg != 2'h0);
            oe_n_next = phase_reg[1];
         end
         eeprom_host_pkg::ST_TX:
         begin
            scl_next = (phase_reg == 2'h1) || (phase_reg == 2'h2);
            oe_n_next = (bit_reg == `ACK_SLOT) || sh_reg[7];
         end
         eeprom_host_pkg::ST_RX:
         begin
            scl_next = (phase_reg == 2'h1) || (phase_reg == 2'h2);
            oe_n_next = (bit_reg != `ACK_SLOT) || (left_reg == 5'h01);
         end
         eeprom_host_pkg::ST_WAIT:
            scl_next = 1'b0;
         default:
         begin
            scl_next = 1'b1;
            oe_n_next = 1'b1;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         scl_o <= 1'b1;
         sda_oe_n_o <= 1'b1;
      end
      else
      begin
         scl_o <= scl_next;
         sda_oe_n_o <= oe_n_next;
      end
   end

   assign sda_o = 1'b0;

   // ***************************************************************
   // two-entry read buffer
   // ***************************************************************
   assign push = (state_reg == eeprom_host_pkg::ST_RX) && slot_end
                 && (bit_reg == `LAST_DATA_BIT);
   assign pop = rdata_valid_o && rdata_ready_i;
   assign rdata_valid_o = (buf_cnt_reg != 2'h0);
   assign rdata_o = buf_mem[buf_rd_reg];

   always_ff @(posedge ref_clk_i)
   begin
      if (push)
         buf_mem[buf_wr_reg] <= sh_reg;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         buf_wr_reg <= 1'b0;
         buf_rd_reg <= 1'b0;
         buf_cnt_reg <= 2'h0;
      end
      else
      begin
         if (push)
            buf_wr_reg <= !buf_wr_reg;
         if (pop)
            buf_rd_reg <= !buf_rd_reg;
         buf_cnt_reg <= buf_cnt_reg + {1'b0, push} - {1'b0, pop};
      end
   end

   // ***************************************************************
   // checks
   // ***************************************************************
   a_start_shape: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (state_reg == eeprom_host_pkg::ST_START && phase_reg == 2'h2 && qcnt_reg == `QTR_W'(1))
      |-> (scl_o && !sda_oe_n_o && $past(sda_oe_n_o, 2)))
      else $error("start not a falling data edge under high clock");

   a_data_stable: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (scl_o && $past(scl_o) && $changed(sda_oe_n_o))
      |-> ($past(state_reg) == eeprom_host_pkg::ST_START
           || $past(state_reg) == eeprom_host_pkg::ST_STOP))
      else $error("data moved under high clock outside start or stop");

   a_ack_release: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (state_reg == eeprom_host_pkg::ST_TX && bit_reg == `ACK_SLOT && qcnt_reg == `QTR_W'(1))
      |-> sda_oe_n_o)
      else $error("data not released in acknowledge slot");

   a_dev_code: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ($rose(state_reg == eeprom_host_pkg::ST_TX) && (stage_reg == eeprom_host_pkg::SG_DEV_W
       || stage_reg == eeprom_host_pkg::SG_DEV_R))
      |-> (sh_reg[7:4] == DEV_TYPE_CODE && sh_reg[3:1] == addr_reg[10:8]))
      else $error("device address byte malformed");

   a_page_limit: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (stage_reg == eeprom_host_pkg::SG_DATA) |-> (left_reg <= `PAGE_BYTES))
      else $error("page write longer than sixteen bytes");

   a_rx_ack: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (state_reg == eeprom_host_pkg::ST_RX && bit_reg == `ACK_SLOT && left_reg != 5'h01
       && qcnt_reg == `QTR_W'(1)) |-> !sda_oe_n_o)
      else $error("no acknowledge before a further read byte");

   a_rx_last: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (state_reg == eeprom_host_pkg::ST_RX && slot_end && bit_reg == `ACK_SLOT
       && left_reg == 5'h01)
      |=> (state_reg == eeprom_host_pkg::ST_STOP && sda_oe_n_o && $past(sda_oe_n_o)))
      else $error("last read byte not followed by release and stop");

   a_srst_free: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (stage_reg == eeprom_host_pkg::SG_SRST1 && state_reg == eeprom_host_pkg::ST_TX
       && qcnt_reg == `QTR_W'(1)) |-> sda_oe_n_o)
      else $error("data driven during reset clocks");

   a_poll_retry: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (state_reg == eeprom_host_pkg::ST_STOP && slot_end && retry_reg)
      |=> (state_reg == eeprom_host_pkg::ST_START && !done_o))
      else $error("busy poll did not retry");

   a_buf_room: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      push |-> (buf_cnt_reg != `BUF_DEPTH || pop))
      else $error("read buffer overrun");

endmodule : eeprom_host
`default_nettype wire

// ---- hw/eeprom_host_params.svh ----
// Purpose: timing counts, field values and sizes for the serial EEPROM host
// Assumes: 200 MHz ref_clk_i
// Notes: definitions only
`ifndef EEPROM_HOST_PARAMS_SVH
`define EEPROM_HOST_PARAMS_SVH

`define CLK_PERIOD_NS 5
// one quarter of a bit slot; two quarters low, two high
`define T_QTR_NS 600
`define QTR_CYC ((`T_QTR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define QTR_W 8
`define PAGE_BYTES 5'h10
`define ACK_SLOT 4'h8
`define LAST_DATA_BIT 4'h7
`define DUMMY_BYTE 8'hff
`define CMD_WRITE 1'b0
`define CMD_READ 1'b1
`define BUF_DEPTH 2'h2

`endif

// ---- hw/eeprom_host_pkg.sv ----
// Purpose: types shared by the serial EEPROM host
// Assumes: nothing
// Notes: states, stages and operations
package eeprom_host_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_START = 3'h1,
      ST_TX = 3'h2,
      ST_RX = 3'h3,
      ST_STOP = 3'h4,
      ST_WAIT = 3'h5
   } state_t;

   typedef enum logic [2:0] {
      SG_DEV_W = 3'h0,
      SG_WADDR = 3'h1,
      SG_DATA = 3'h2,
      SG_DEV_R = 3'h3,
      SG_RDATA = 3'h4,
      SG_SRST1 = 3'h5,
      SG_SRST2 = 3'h6
   } stage_t;

   typedef enum logic [2:0] {
      OP_WRITE = 3'h0,
      OP_READ = 3'h1,
      OP_CUR_READ = 3'h2,
      OP_POLL = 3'h3,
      OP_SRESET = 3'h4
   } op_t;

endpackage : eeprom_host_pkg

// ---- verif/eeprom_model.sv ----
// Purpose: behavioural two-wire EEPROM slave facing the host
// Assumes: bench resolves the data line with a pull-up
// Notes: programming time is a parameter; memory starts with a known pattern
`timescale 1ns/1ps
`default_nettype none
module eeprom_model #(
   parameter int WC_NS = 20000
) (
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_low_o
);
   // value arbitrary; the bench changes it to provoke a refusal
   logic [3:0] code = 4'h6;
   logic [7:0] mem [0:2047];
   logic [7:0] page [0:15];
   logic [15:0] pv;
   logic [10:0] ptr;
   logic [10:0] base;
   logic [7:0] sh;
   logic [7:0] rbyte;
   logic [3:0] off;
   logic [2:0] hi;
   logic busy = 1'b0;
   logic acking = 1'b0;
   int bitc = 0;
   int st = 0;
   int cnt = 0;
   int n_busy_starts = 0;
   wire logic scl_f;
   wire logic sda_f;
   // inertial delay drops pulses up to 100 ns on both lines
   assign #101 scl_f = scl_i;
   assign #101 sda_f = sda_i;
   initial
   begin
      sda_low_o = 1'b0;
      ptr = 11'h000;
      for (int i = 0; i < 2048; i++)
         mem[i] = i[7:0] ^ {5'h00, i[10:8]} ^ 8'h5a;
   end
   // ***************************************
   // start and stop
   // ***************************************
   always @(negedge sda_f)
   begin
      if (scl_f === 1'b1 && busy)
         n_busy_starts++;
      else if (scl_f === 1'b1)
      begin
         st = 1;
         bitc = 0;
      end
   end
   always @(posedge sda_f)
   begin
      if (scl_f === 1'b1 && !busy)
      begin
         if (st == 3 && cnt > 0)
         begin
            for (int i = 0; i < 16; i++)
               if (pv[i])
                  mem[{base[10:4], i[3:0]}] = page[i];
            ptr = {base[10:4], base[3:0] + cnt[3:0]};
            busy = 1'b1;
         end
         st = 0;
      end
   end
   always @(posedge busy)
   begin
      #(WC_NS);
      busy = 1'b0;
   end
   // ***************************************
   // bit and byte handling
   // ***************************************
   always @(posedge scl_f)
   begin
      if (st != 0 && !busy && bitc < 8)
      begin
         sh = {sh[6:0], sda_f};
         bitc++;
      end
      else if (st != 0 && !busy)
      begin
         if (st == 4 && !acking && sda_f === 1'b0)
         begin
            rbyte = mem[ptr];
            ptr = ptr + 11'h001;
         end
         else if (st == 4 && !acking)
            st = 0;
         bitc = 0;
      end
   end
   always @(negedge scl_f)
   begin
      if (st != 0 && !busy)
      begin
         acking = (bitc == 8 && st != 4);
         if (acking && st == 1 && sh[7:4] != code)
         begin
            acking = 1'b0;
            st = 0;
         end
         else if (acking && st == 1 && sh[0])
         begin
            st = 4;
            ptr[10:8] = sh[3:1];
            rbyte = mem[ptr];
            ptr = ptr + 11'h001;
         end
         else if (acking && st == 1)
         begin
            hi = sh[3:1];
            st = 2;
         end
         else if (acking && st == 2)
         begin
            base = {hi, sh};
            ptr = base;
            off = sh[3:0];
            cnt = 0;
            pv = 16'h0000;
            st = 3;
         end
         else if (acking)
         begin
            page[off] = sh;
            pv[off] = 1'b1;
            off = off + 4'h1;
            cnt++;
         end
         sda_low_o = acking | (st == 4 && bitc < 8 && !rbyte[7 - bitc]);
      end
      else
         sda_low_o = 1'b0;
   end
endmodule : eeprom_model
`default_nettype wire

// ---- verif/tb_eeprom_host.sv ----
// Purpose: self-checking bench for the serial EEPROM host
// Assumes: behavioural slave model with pull-up on the data line
// Notes: one task per scenario; waits are bounded
`timescale 1ns/1ps
`default_nettype none
module tb_eeprom_host;
   logic ref_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic cmd_valid_i = 1'b0;
   eeprom_host_pkg::op_t cmd_op_i = eeprom_host_pkg::OP_WRITE;
   logic [10:0] cmd_addr_i = 11'h000;
   logic [4:0] cmd_len_i = 5'h00;
   logic wdata_valid_i = 1'b0;
   logic [7:0] wdata_i = 8'h00;
   logic rdata_ready_i = 1'b0;
   logic cmd_ready_o, wdata_ready_o, rdata_valid_o, done_o, err_o, scl_o, sda_oe_n_o, sda_o;
   logic [7:0] rdata_o;
   logic sda_low;
   wire logic sda_bus;
   logic [7:0] wb [0:3];
   logic [7:0] got [0:7];
   logic [2:0] n_got;
   int errors = 0;
   int n_checks = 0;
   // released line floats high through the pull-up
   assign sda_bus = ~(~sda_oe_n_o | sda_low);
   always #2.5 ref_clk_i = ~ref_clk_i;
   eeprom_host #(.DEV_TYPE_CODE(4'h6)) u_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i),
      .cmd_addr_i(cmd_addr_i), .cmd_len_i(cmd_len_i), .wdata_valid_i(wdata_valid_i),
      .wdata_ready_o(wdata_ready_o), .wdata_i(wdata_i), .rdata_valid_o(rdata_valid_o),
      .rdata_ready_i(rdata_ready_i), .rdata_o(rdata_o), .done_o(done_o), .err_o(err_o),
      .scl_o(scl_o), .sda_i(sda_bus), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o));
   eeprom_model u_eep (.scl_i(scl_o), .sda_i(sda_bus), .sda_low_o(sda_low));
   // ***************************************
   // shared tasks
   // ***************************************
   function automatic logic [7:0] init_val(input logic [10:0] a);
      return a[7:0] ^ {5'h00, a[10:8]} ^ 8'h5a;
   endfunction : init_val
   task automatic final_report;
      if (errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : final_report
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic run_cmd(input eeprom_host_pkg::op_t op, input logic [10:0] addr,
      input logic [4:0] len, input int stall, input logic exp_err);
      int wi;
      int cyc;
      logic ok;
      logic hw;
      wi = 0;
      n_got = 3'h0;
      ok = 1'b0;
      cmd_op_i = op;
      cmd_addr_i = addr;
      cmd_len_i = len;
      cmd_valid_i = 1'b1;
      for (cyc = 0; cyc < 100 && !ok; cyc++)
      begin
         @(negedge ref_clk_i);
         ok = (cmd_ready_o === 1'b1);
         @(posedge ref_clk_i);
         #1;
      end
      cmd_valid_i = 1'b0;
      if (!ok)
      begin
         errors++;
         final_report();
      end
      ok = 1'b0;
      for (cyc = 0; cyc < 70000 && !ok; cyc++)
      begin
         wdata_valid_i = (op == eeprom_host_pkg::OP_WRITE) && (wi < len);
         wdata_i = wb[wi[1:0]];
         rdata_ready_i = (cyc >= stall);
         @(negedge ref_clk_i);
         if (stall != 0 && cyc == stall - 1)
            check("buffer full and bus held", {rdata_valid_o, scl_o}, 2'b10);
         hw = wdata_valid_i && (wdata_ready_o === 1'b1);
         if (rdata_ready_i && rdata_valid_o === 1'b1)
         begin
            got[n_got] = rdata_o;
            n_got++;
         end
         ok = (done_o === 1'b1);
         @(posedge ref_clk_i);
         #1;
         if (hw)
            wi++;
      end
      wdata_valid_i = 1'b0;
      rdata_ready_i = 1'b0;
      if (!ok)
      begin
         errors++;
         final_report();
      end
      check("error flag", err_o, exp_err);
   endtask : run_cmd
   // ***************************************
   // scenarios
   // ***************************************
   task automatic t_page_write;
      wb[0] = 8'ha5;
      wb[1] = 8'h3c;
      run_cmd(eeprom_host_pkg::OP_WRITE, 11'h3ff, 5'h02, 0, 1'b0);
      check("byte at 3ff", u_eep.mem[11'h3ff], 8'ha5);
      check("byte at 3f0", u_eep.mem[11'h3f0], 8'h3c);
      check("byte at 400", u_eep.mem[11'h400], init_val(11'h400));
      check("pointer after write", u_eep.ptr, 11'h3f1);
   endtask : t_page_write
   task automatic t_poll;
      run_cmd(eeprom_host_pkg::OP_POLL, 11'h300, 5'h00, 0, 1'b0);
      check("refused polls", u_eep.n_busy_starts != 0, 1'b1);
      check("programming over", u_eep.busy, 1'b0);
   endtask : t_poll
   task automatic t_cur_read;
      run_cmd(eeprom_host_pkg::OP_CUR_READ, 11'h300, 5'h02, 0, 1'b0);
      check("bytes read", n_got, 3'h2);
      check("first byte", got[0], init_val(11'h3f1));
      check("second byte", got[1], init_val(11'h3f2));
   endtask : t_cur_read
   task automatic t_stall_read;
      run_cmd(eeprom_host_pkg::OP_READ, 11'h7fe, 5'h03, 25000, 1'b0);
      check("bytes read", n_got, 3'h3);
      check("byte 7fe", got[0], init_val(11'h7fe));
      check("byte 7ff", got[1], init_val(11'h7ff));
      check("byte 000", got[2], init_val(11'h000));
   endtask : t_stall_read
   task automatic t_sreset;
      run_cmd(eeprom_host_pkg::OP_SRESET, 11'h000, 5'h00, 0, 1'b0);
      check("pointer kept", u_eep.ptr, 11'h001);
   endtask : t_sreset
   task automatic t_wrong_code;
      u_eep.code = 4'h7;
      run_cmd(eeprom_host_pkg::OP_CUR_READ, 11'h000, 5'h00, 0, 1'b1);
      check("bytes read", n_got, 3'h0);
      u_eep.code = 4'h6;
   endtask : t_wrong_code
   initial
   begin
      repeat (20) @(posedge ref_clk_i);
      #1;
      check("reset outputs", {scl_o, sda_oe_n_o, cmd_ready_o, done_o, err_o, wdata_ready_o,
         rdata_valid_o, sda_o}, 8'he0);
      reset_i = 1'b0;
      t_page_write();
      t_poll();
      t_cur_read();
      t_stall_read();
      t_sreset();
      t_wrong_code();
      final_report();
   end
endmodule : tb_eeprom_host
`default_nettype wire
